//--- lcd_decoder.sv
// Legacy command decoder: takes pre-tokenised legacy commands and drives
// setpoints, limits, output enable, protection clear and query replies.
// Assumes the host parser delivers one opcode per cmd_valid pulse and that
// the surrounding supply supplies measurements, identity and permit status.
// Operation
// - Reset command restores setpoint, limit and OVP defaults, turns output off and pulses dev_reset.
// - Error query returns next error queue entry as a 16-bit error code.
// - Model query returns model identifier and version.
// - Current readback returns measured output current.
// - Current ceiling sets upper current soft limit; query returns it.
// - Current setpoint changes immediately; query returns it.
// - Output switch enables or disables output; query returns state.
// - Over-voltage trip sets protection threshold; query returns it.
// - Firmware query returns main firmware version.
// - Protection clear releases trips only, setpoints unchanged.
// - Voltage ceiling sets upper voltage soft limit; query returns it.
// - Voltage readback returns measured output voltage.
// - Voltage setpoint changes immediately; query returns it.
// - Value writes rejected with error when remote or calibration state forbids.
// - Commands act on this unit only; nothing forwarded to slaves.
// - Every query reply carries the queried command identity.
// - Reset leaves legacy fault registers untouched.
// - A trip may switch output off depending on configuration.
// - Error queue FIFO; overflow replaces newest; empty reads zero.
`include "lcd_regs.svh"
module lcd_decoder #(
	parameter int VW    = 16,
	parameter int DEPTH = 4
) (
	input  wire logic          ref_clk,
	input  wire logic          sys_rst,
	input  wire logic          cmd_valid,
	input  wire logic [3:0]    cmd_op,
	input  wire logic          cmd_query,
	input  wire logic          cmd_known,
	input  wire logic [VW-1:0] cmd_arg,
	input  wire logic          write_permit,
	input  wire logic [VW-1:0] meas_amps,
	input  wire logic [VW-1:0] meas_volts,
	input  wire logic [VW-1:0] model_version,
	input  wire logic [VW-1:0] fw_version,
	input  wire logic          prot_trip,
	input  wire logic          trip_disables_out,
	output logic               cmd_ready,
	output logic               rsp_valid,
	output logic [3:0]         rsp_op,
	output logic [VW-1:0]      rsp_data,
	output logic [VW-1:0]      amps_set,
	output logic [VW-1:0]      amps_ceil,
	output logic [VW-1:0]      volts_set,
	output logic [VW-1:0]      volts_ceil,
	output logic [VW-1:0]      ovp_level,
	output logic               out_enable,
	output logic               prot_latched,
	output logic               fault_reg,
	output logic               dev_reset
);
	localparam int AW = $clog2(DEPTH);
	lcd_pkg::lcd_state_e state;
	logic                take;
	logic                is_write;
	logic                write_ok;
	logic                push;
	logic [15:0]         push_code;
	logic                pop;
	logic [15:0]         eq_mem [DEPTH];
	logic [AW-1:0]       eq_rd;
	logic [AW-1:0]       eq_wr;
	logic [AW:0]         eq_cnt;
	logic [15:0]         eq_head;

	// Accept one command while no reply is pending
	assign cmd_ready = (state == lcd_pkg::LCD_IDLE);
	assign take      = cmd_valid && cmd_ready;
	assign is_write  = cmd_known && !cmd_query && (cmd_op == `LCD_OP_AMPS_CEIL
		|| cmd_op == `LCD_OP_AMPS_SET || cmd_op == `LCD_OP_OUT_SW
		|| cmd_op == `LCD_OP_OVP_SET || cmd_op == `LCD_OP_VOLT_CEIL
		|| cmd_op == `LCD_OP_VOLT_SET);
	assign write_ok  = take && is_write && write_permit;
	assign pop       = take && cmd_known && cmd_op == `LCD_OP_ERR_Q;
	assign eq_head   = (eq_cnt == '0) ? `LCD_ERR_NONE : eq_mem[eq_rd];

	// Error source selection
	always_comb begin
		push      = 1'b0;
		push_code = `LCD_ERR_NONE;
		if (take && !cmd_known) begin
			push      = 1'b1;
			push_code = `LCD_ERR_CMD;
		end else if (take && is_write && !write_permit) begin
			push      = 1'b1;
			push_code = `LCD_ERR_EXEC;
		end
	end

	// Error queue pointers, FIFO order
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			eq_rd  <= '0;
			eq_wr  <= '0;
			eq_cnt <= '0;
		end else begin
			if (pop && eq_cnt != '0) begin
				eq_rd  <= AW'((eq_rd + 1'b1) % DEPTH);
				eq_cnt <= eq_cnt - 1'b1;
			end else if (push && eq_cnt < (AW+1)'(DEPTH)) begin
				eq_wr  <= AW'((eq_wr + 1'b1) % DEPTH);
				eq_cnt <= eq_cnt + 1'b1;
			end
		end
	end

	// Error queue storage; full queue overwrites newest with overflow code
	always_ff @(posedge ref_clk) begin
		if (push && !pop) begin
			if (eq_cnt < (AW+1)'(DEPTH))
				eq_mem[eq_wr] <= push_code;
			else
				eq_mem[AW'((eq_wr + DEPTH - 1) % DEPTH)] <= `LCD_ERR_OVERFLOW;
		end
	end

	// Setpoints and limits; reset command restores defaults
	always_ff @(posedge ref_clk) begin
		if (sys_rst || (take && cmd_known && cmd_op == `LCD_OP_RESET)) begin
			amps_set   <= VW'(`LCD_SET_RESET);
			volts_set  <= VW'(`LCD_SET_RESET);
			amps_ceil  <= VW'(`LCD_CEIL_RESET);
			volts_ceil <= VW'(`LCD_CEIL_RESET);
			ovp_level  <= VW'(`LCD_CEIL_RESET);
		end else if (write_ok) begin
			case (cmd_op)
				`LCD_OP_AMPS_CEIL: amps_ceil <= cmd_arg;
				`LCD_OP_AMPS_SET:  amps_set  <= cmd_arg;
				`LCD_OP_OVP_SET:   ovp_level <= cmd_arg;
				`LCD_OP_VOLT_CEIL: volts_ceil <= cmd_arg;
				`LCD_OP_VOLT_SET:  volts_set <= cmd_arg;
				default: ;
			endcase
		end
	end

	// Output enable, trip may force it off
	always_ff @(posedge ref_clk) begin
		if (sys_rst || (take && cmd_known && cmd_op == `LCD_OP_RESET))
			out_enable <= 1'b0;
		else if (prot_trip && trip_disables_out)
			out_enable <= 1'b0;
		else if (write_ok && cmd_op == `LCD_OP_OUT_SW)
			out_enable <= cmd_arg[0];
	end

	// Protection latch: clear command releases it, set wins over clear
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			prot_latched <= 1'b0;
		else if (prot_trip)
			prot_latched <= 1'b1;
		else if (take && cmd_known && cmd_op == `LCD_OP_PROT_CLR)
			prot_latched <= 1'b0;
	end

	// Legacy fault record survives the reset command
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			fault_reg <= 1'b0;
		else if (prot_trip)
			fault_reg <= 1'b1;
	end

	// Reset pulse to the rest of the supply
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			dev_reset <= 1'b0;
		else
			dev_reset <= take && cmd_known && cmd_op == `LCD_OP_RESET;
	end

	// Reply state
	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			state <= lcd_pkg::LCD_IDLE;
		else begin
			case (state)
				lcd_pkg::LCD_IDLE:
					if (take && cmd_known && (cmd_query || cmd_op == `LCD_OP_ERR_Q
						|| cmd_op == `LCD_OP_MODEL_Q || cmd_op == `LCD_OP_AMPS_RD
						|| cmd_op == `LCD_OP_FW_Q || cmd_op == `LCD_OP_VOLT_RD))
						state <= lcd_pkg::LCD_REPLY;
				lcd_pkg::LCD_REPLY: state <= lcd_pkg::LCD_IDLE;
				default: state <= lcd_pkg::LCD_IDLE;
			endcase
		end
	end
	assign rsp_valid = (state == lcd_pkg::LCD_REPLY);

	// Reply data, tagged with the queried opcode
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rsp_op   <= 4'h0;
			rsp_data <= '0;
		end else if (take) begin
			rsp_op <= cmd_op;
			case (cmd_op)
				`LCD_OP_ERR_Q:     rsp_data <= VW'(eq_head);
				`LCD_OP_MODEL_Q:   rsp_data <= model_version;
				`LCD_OP_AMPS_RD:   rsp_data <= meas_amps;
				`LCD_OP_AMPS_CEIL: rsp_data <= amps_ceil;
				`LCD_OP_AMPS_SET:  rsp_data <= amps_set;
				`LCD_OP_OUT_SW:    rsp_data <= VW'(out_enable);
				`LCD_OP_OVP_SET:   rsp_data <= ovp_level;
				`LCD_OP_FW_Q:      rsp_data <= fw_version;
				`LCD_OP_VOLT_CEIL: rsp_data <= volts_ceil;
				`LCD_OP_VOLT_RD:   rsp_data <= meas_volts;
				`LCD_OP_VOLT_SET:  rsp_data <= volts_set;
				default:           rsp_data <= '0;
			endcase
		end
	end

	// Assertions
	sequence s_set_cmd;
		take && is_write && write_permit && cmd_op == `LCD_OP_AMPS_SET;
	endsequence
	a_amps_set_takes: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_set_cmd |=> amps_set == $past(cmd_arg)) else $error("amps setpoint not taken");
	a_volts_set_takes: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && write_ok && cmd_op == `LCD_OP_VOLT_SET |=> volts_set == $past(cmd_arg))
		else $error("volts setpoint not taken");
	a_denied_holds: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && is_write && !write_permit && cmd_op != `LCD_OP_RESET |=> $stable(amps_set)
		&& $stable(volts_set) && $stable(ovp_level)) else $error("denied write changed value");
	a_clear_keeps_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && cmd_known && cmd_op == `LCD_OP_PROT_CLR |=> $stable(amps_set)
		&& $stable(volts_set)) else $error("protection clear changed setpoint");
	a_fault_kept: assert property (@(posedge ref_clk) disable iff (sys_rst)
		fault_reg |=> fault_reg) else $error("fault record lost");
	a_trip_off: assert property (@(posedge ref_clk) disable iff (sys_rst)
		prot_trip && trip_disables_out |=> !out_enable) else $error("trip left output on");
	a_reply_tag: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && cmd_known && cmd_op == `LCD_OP_FW_Q |=> rsp_valid && rsp_op == `LCD_OP_FW_Q
		&& rsp_data == $past(fw_version)) else $error("firmware reply wrong");
	a_unknown_err: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && !cmd_known && eq_cnt == '0 |=> eq_cnt == 1 && eq_head == `LCD_ERR_CMD)
		else $error("unknown command not queued");
	a_empty_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		eq_cnt == '0 |-> eq_head == `LCD_ERR_NONE) else $error("empty queue not zero");

	// Limits and protection level follow an allowed write
	sequence s_ceil_cmd;
		write_ok && cmd_op == `LCD_OP_AMPS_CEIL;
	endsequence
	a_amps_ceil_takes: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_ceil_cmd |=> amps_ceil == $past(cmd_arg))
		else $error("amps ceiling not taken");
	a_volts_ceil_takes: assert property (@(posedge ref_clk) disable iff (sys_rst)
		write_ok && cmd_op == `LCD_OP_VOLT_CEIL |=> volts_ceil == $past(cmd_arg))
		else $error("volts ceiling not taken");
	a_ovp_takes: assert property (@(posedge ref_clk) disable iff (sys_rst)
		write_ok && cmd_op == `LCD_OP_OVP_SET |=> ovp_level == $past(cmd_arg))
		else $error("overvoltage level not taken");
	// Output switch follows bit 0 unless a configured trip holds it off
	a_out_switch: assert property (@(posedge ref_clk) disable iff (sys_rst)
		write_ok && cmd_op == `LCD_OP_OUT_SW && !(prot_trip && trip_disables_out)
		|=> out_enable == $past(cmd_arg[0])) else $error("output switch not taken");

	// Reset command: one pulse, defaults back, fault record untouched
	sequence s_reset_cmd;
		take && cmd_known && cmd_op == `LCD_OP_RESET;
	endsequence
	a_reset_defaults: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_reset_cmd |=> dev_reset && !out_enable && amps_set == VW'(`LCD_SET_RESET)
		&& volts_ceil == VW'(`LCD_CEIL_RESET)) else $error("reset command left state");
	a_reset_keeps_fault: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_reset_cmd |=> fault_reg == ($past(fault_reg) || $past(prot_trip)))
		else $error("reset command touched fault record");

	// A trip is recorded and latched; clear releases only without a trip
	a_trip_records: assert property (@(posedge ref_clk) disable iff (sys_rst)
		prot_trip |=> fault_reg && prot_latched) else $error("trip not recorded");
	a_clear_releases: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && cmd_known && cmd_op == `LCD_OP_PROT_CLR && !prot_trip |=> !prot_latched)
		else $error("protection clear did not release");

	// Every query answers once, tagged, and blocks the next command meanwhile
	sequence s_query_take;
		take && cmd_known && cmd_query;
	endsequence
	a_query_tagged: assert property (@(posedge ref_clk) disable iff (sys_rst)
		s_query_take |=> rsp_valid && rsp_op == $past(cmd_op))
		else $error("query reply untagged");
	a_reply_once: assert property (@(posedge ref_clk) disable iff (sys_rst)
		rsp_valid |-> !cmd_ready ##1 !rsp_valid) else $error("reply not single cycle");

	// Error queue: pops drop one, a full queue marks overflow in place
	a_pop_drops_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
		pop && eq_cnt != '0 |=> eq_cnt == $past(eq_cnt) - 1'b1)
		else $error("pop did not drop one entry");
	a_full_marks: assert property (@(posedge ref_clk) disable iff (sys_rst)
		push && !pop && eq_cnt == (AW+1)'(DEPTH) |=> eq_cnt == $past(eq_cnt)
		&& eq_mem[AW'((eq_wr + DEPTH - 1) % DEPTH)] == `LCD_ERR_OVERFLOW)
		else $error("overflow not marked");
	a_refused_err: assert property (@(posedge ref_clk) disable iff (sys_rst)
		take && is_write && !write_permit && eq_cnt == '0
		|=> eq_cnt == 1 && eq_head == `LCD_ERR_EXEC) else $error("refused write not queued");
endmodule : lcd_decoder

//--- lcd_regs.svh
// Constants for the legacy command decoder: opcodes, error codes, reset values.
// Assumes the includer needs plain macros only; no logic lives here.
`ifndef LCD_REGS_SVH
`define LCD_REGS_SVH
`define LCD_OP_RESET      4'h0
`define LCD_OP_ERR_Q      4'h1
`define LCD_OP_MODEL_Q    4'h2
`define LCD_OP_AMPS_RD    4'h3
`define LCD_OP_AMPS_CEIL  4'h4
`define LCD_OP_AMPS_SET   4'h5
`define LCD_OP_OUT_SW     4'h6
`define LCD_OP_OVP_SET    4'h7
`define LCD_OP_FW_Q       4'h8
`define LCD_OP_PROT_CLR   4'h9
`define LCD_OP_VOLT_CEIL  4'hA
`define LCD_OP_VOLT_RD    4'hB
`define LCD_OP_VOLT_SET   4'hC
`define LCD_ERR_NONE      16'h0000
`define LCD_ERR_CMD       16'hFF9C
`define LCD_ERR_OVERFLOW  16'hFEA2
`define LCD_ERR_EXEC      16'hFF38
`define LCD_SET_RESET     16'h0000
`define LCD_CEIL_RESET    16'hFFFF
`endif

//--- lcd_pkg.sv
// Types shared by the legacy command decoder.
// Assumes lcd_regs.svh supplies the numeric constants.
package lcd_pkg;
	typedef enum logic [1:0] {
		LCD_IDLE  = 2'b00,
		LCD_REPLY = 2'b01
	} lcd_state_e;
endpackage : lcd_pkg

//--- lcd_host_model.sv
// Host model: sends one legacy command per call on the decoder strobe.
// Assumes one caller at a time and a free-running ref_clk.
module lcd_host_model (
	input  wire logic        ref_clk,
	input  wire logic        cmd_ready,
	input  wire logic        rsp_valid,
	input  wire logic [3:0]  rsp_op,
	input  wire logic [15:0] rsp_data,
	output logic             cmd_valid,
	output logic [3:0]       cmd_op,
	output logic             cmd_query,
	output logic             cmd_known,
	output logic [15:0]      cmd_arg
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle strobe at time zero
	initial begin
		cmd_valid = 1'h0;
		cmd_op    = 4'h0;
		cmd_query = 1'h0;
		cmd_known = 1'h1;
		cmd_arg   = 16'h0000;
	end
	// Drive on falling edge, hold until taken, then release
	task automatic send(input logic [3:0] op, input logic q, input logic k,
		input logic [15:0] arg, output logic [15:0] rd, output logic [3:0] ro);
		@(negedge ref_clk);
		cmd_valid = 1'h1;
		cmd_op    = op;
		cmd_query = q;
		cmd_known = k;
		cmd_arg   = arg;
		while (cmd_ready !== 1'h1) @(negedge ref_clk);
		@(negedge ref_clk);
		cmd_valid = 1'h0;
		cmd_arg   = ~arg; // Stale value not held
		rd        = (rsp_valid === 1'h1) ? rsp_data : 16'hxxxx;
		ro        = rsp_op;
	endtask : send
endmodule : lcd_host_model

//--- legacy_command_decoder_tb_top.sv
// Bench for the legacy command decoder: command table, then corner cases.
// Assumes lcd_host_model drives the command side; the bench drives status.
`include "lcd_regs.svh"
module legacy_command_decoder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [3:0]  op;
		logic        q;
		logic [2:0]  sel;
		logic [15:0] arg;
		logic [15:0] exp;
	} lcd_row_s;
	logic        ref_clk = 1'h0, sys_rst = 1'h1, write_permit = 1'h1, f;
	logic        prot_trip = 1'h0, trip_disables_out = 1'h0;
	logic        cmd_valid, cmd_query, cmd_known, cmd_ready, rsp_valid;
	logic        out_enable, prot_latched, fault_reg, dev_reset;
	logic [3:0]  cmd_op, rsp_op, ro;
	logic [15:0] meas_amps = 16'h1234, meas_volts = 16'h5678;
	logic [15:0] model_version = 16'h0A0B, fw_version = 16'h0C0D;
	logic [15:0] cmd_arg, rsp_data, amps_set, amps_ceil, volts_set, volts_ceil, ovp_level, rd;
	int          error_cnt = 0, cmp_count = 0;
	logic [15:0] exp_q [5] = '{`LCD_ERR_CMD, `LCD_ERR_CMD, `LCD_ERR_CMD,
		`LCD_ERR_OVERFLOW, `LCD_ERR_NONE};
	lcd_row_s    rows [17] = '{
		'{4'h5, 1'h0, 3'h0, 16'h0100, 16'h0100}, '{4'h4, 1'h0, 3'h1, 16'h0200, 16'h0200},
		'{4'hC, 1'h0, 3'h2, 16'h0300, 16'h0300}, '{4'hA, 1'h0, 3'h3, 16'h0400, 16'h0400},
		'{4'h7, 1'h0, 3'h4, 16'h0500, 16'h0500}, '{4'h6, 1'h0, 3'h5, 16'h0001, 16'h0001},
		'{4'h5, 1'h1, 3'h6, 16'h0000, 16'h0100}, '{4'h4, 1'h1, 3'h6, 16'h0000, 16'h0200},
		'{4'hC, 1'h1, 3'h6, 16'h0000, 16'h0300}, '{4'hA, 1'h1, 3'h6, 16'h0000, 16'h0400},
		'{4'h7, 1'h1, 3'h6, 16'h0000, 16'h0500}, '{4'h6, 1'h1, 3'h6, 16'h0000, 16'h0001},
		'{4'h3, 1'h0, 3'h6, 16'h0000, 16'h1234}, '{4'hB, 1'h0, 3'h6, 16'h0000, 16'h5678},
		'{4'h2, 1'h0, 3'h6, 16'h0000, 16'h0A0B}, '{4'h8, 1'h0, 3'h6, 16'h0000, 16'h0C0D},
		'{4'h1, 1'h0, 3'h6, 16'h0000, 16'h0000}};
	// Design and host
	lcd_decoder #(.VW(16), .DEPTH(4)) dut (.ref_clk, .sys_rst, .cmd_valid, .cmd_op,
		.cmd_query, .cmd_known, .cmd_arg, .write_permit, .meas_amps, .meas_volts,
		.model_version, .fw_version, .prot_trip, .trip_disables_out, .cmd_ready,
		.rsp_valid, .rsp_op, .rsp_data, .amps_set, .amps_ceil, .volts_set, .volts_ceil,
		.ovp_level, .out_enable, .prot_latched, .fault_reg, .dev_reset);
	lcd_host_model host (.ref_clk, .cmd_ready, .rsp_valid, .rsp_op, .rsp_data,
		.cmd_valid, .cmd_op, .cmd_query, .cmd_known, .cmd_arg);
	// Compare and count
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Verdict and end of run
	task automatic finish_test;
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : finish_test
	// Output selected by a table row
	function automatic logic [15:0] pick(input logic [2:0] s);
		case (s)
			3'h0: return amps_set;
			3'h1: return amps_ceil;
			3'h2: return volts_set;
			3'h3: return volts_ceil;
			3'h4: return ovp_level;
			3'h5: return {15'h0000, out_enable};
			default: return rd;
		endcase
	endfunction : pick
	// Clock and watchdog
	always #25 ref_clk = ~ref_clk;
	initial begin
		#(50 * 3000);
		error_cnt++;
		finish_test();
	end
	// Main sequence
	initial begin
		repeat (6) @(negedge ref_clk);
		sys_rst = 1'h0;
		chk("amps_set", `LCD_SET_RESET, amps_set);
		chk("volts_ceil", `LCD_CEIL_RESET, volts_ceil);
		chk("cmd_ready", 16'h0001, {15'h0000, cmd_ready});
		$display("test reset done");
		foreach (rows[i]) begin
			host.send(rows[i].op, rows[i].q, 1'h1, rows[i].arg, rd, ro);
			chk("table", rows[i].exp, pick(rows[i].sel));
			if (rows[i].sel == 3'h6) begin
				chk("rsp_op", {12'h000, rows[i].op}, {12'h000, ro});
				chk("cmd_ready", 16'h0000, {15'h0000, cmd_ready});
			end
		end
		$display("test table done");
		write_permit = 1'h0;
		host.send(4'h5, 1'h0, 1'h1, 16'h0999, rd, ro);
		write_permit = 1'h1;
		chk("amps_set", 16'h0100, amps_set);
		host.send(4'h1, 1'h0, 1'h1, 16'h0000, rd, ro);
		chk("err_q", `LCD_ERR_EXEC, rd);
		$display("test refused write done");
		repeat (5) host.send(4'h0, 1'h0, 1'h0, 16'h0000, rd, ro);
		foreach (exp_q[i]) begin
			host.send(4'h1, 1'h0, 1'h1, 16'h0000, rd, ro);
			chk("err_q", exp_q[i], rd);
		end
		chk("amps_set", 16'h0100, amps_set);
		$display("test error queue done");
		prot_trip = 1'h1;
		repeat (2) @(negedge ref_clk);
		chk("out_enable", 16'h0001, {15'h0000, out_enable});
		trip_disables_out = 1'h1;
		repeat (2) @(negedge ref_clk);
		chk("out_enable", 16'h0000, {15'h0000, out_enable});
		chk("prot_latched", 16'h0001, {15'h0000, prot_latched});
		host.send(4'h6, 1'h0, 1'h1, 16'h0001, rd, ro);
		chk("out_enable", 16'h0000, {15'h0000, out_enable});
		prot_trip = 1'h0;
		host.send(4'h9, 1'h0, 1'h1, 16'h0000, rd, ro);
		chk("prot_latched", 16'h0000, {15'h0000, prot_latched});
		chk("volts_set", 16'h0300, volts_set);
		$display("test protection done");
		host.send(4'h6, 1'h0, 1'h1, 16'h0001, rd, ro);
		chk("out_enable", 16'h0001, {15'h0000, out_enable});
		host.send(4'h6, 1'h0, 1'h1, 16'h0000, rd, ro);
		chk("out_enable", 16'h0000, {15'h0000, out_enable});
		host.send(4'h6, 1'h0, 1'h1, 16'h0001, rd, ro);
		$display("test output switch done");
		f = fault_reg;
		host.send(4'h0, 1'h0, 1'h1, 16'h0000, rd, ro);
		chk("dev_reset", 16'h0001, {15'h0000, dev_reset});
		chk("amps_set", `LCD_SET_RESET, amps_set);
		chk("ovp_level", `LCD_CEIL_RESET, ovp_level);
		chk("out_enable", 16'h0000, {15'h0000, out_enable});
		chk("fault_reg", {15'h0000, f}, {15'h0000, fault_reg});
		$display("test reset command done");
		host.send(4'h0, 1'h0, 1'h0, 16'h0000, rd, ro);
		sys_rst = 1'h1;
		repeat (2) @(negedge ref_clk);
		sys_rst = 1'h0;
		chk("fault_reg", 16'h0000, {15'h0000, fault_reg});
		host.send(4'h1, 1'h0, 1'h1, 16'h0000, rd, ro);
		chk("err_q", `LCD_ERR_NONE, rd);
		$display("test mid-run reset done");
		finish_test();
	end
endmodule : legacy_command_decoder_tb_top
